// file: hdl/itc_defines.vh
/*
  constants of the two-wire timing and control block: register offsets,
  field positions, reset values and the hold-time table coefficients.
  assumes it is included by bare name into each design file that needs it.
*/
`ifndef ITC_DEFINES_VH
`define ITC_DEFINES_VH

// ----------------------------------------
// register indices and byte addresses
// ----------------------------------------
`define ITC_IDX_CLOCK_DIVIDER 8'h01
`define ITC_IDX_CONTROL_ONE 8'h02
`define ITC_IDX_EVENT_STATUS 8'h04
`define ITC_IDX_EVENT_MASK 8'h05
`define ITC_IDX_BLOCK_STATE 8'h06
`define ITC_ADDR_CLOCK_DIVIDER (`ITC_IDX_CLOCK_DIVIDER << 2)
`define ITC_ADDR_CONTROL_ONE (`ITC_IDX_CONTROL_ONE << 2)
`define ITC_ADDR_EVENT_STATUS (`ITC_IDX_EVENT_STATUS << 2)
`define ITC_ADDR_EVENT_MASK (`ITC_IDX_EVENT_MASK << 2)
`define ITC_ADDR_BLOCK_STATE (`ITC_IDX_BLOCK_STATE << 2)

// ----------------------------------------
// control_one fields
// ----------------------------------------
`define ITC_C1_MODULE_ON 7
`define ITC_C1_IRQ_PERMIT 6
`define ITC_C1_MASTER_SELECT 5
`define ITC_C1_TRANSFER_TX 4
`define ITC_C1_ACK_DRIVE 3
`define ITC_C1_REPEAT_START 2
`define ITC_C1_WAKEUP_PERMIT 1

// ----------------------------------------
// clock_divider fields
// ----------------------------------------
`define ITC_F_MUL_HI 7
`define ITC_F_MUL_LO 6
`define ITC_F_RATE_HI 5
`define ITC_F_RATE_LO 0
`define ITC_MUL_X1 2'b00
`define ITC_MUL_X2 2'b01
`define ITC_MUL_X4 2'b10

// ----------------------------------------
// event bits (status and mask share layout)
// ----------------------------------------
`define ITC_EV_START_DONE 0
`define ITC_EV_STOP_DONE 1
`define ITC_EV_BUS_START 2
`define ITC_EV_BUS_STOP 3
`define ITC_EV_W 4

// ----------------------------------------
// reset values
// ----------------------------------------
`define ITC_RST_CONTROL_ONE 8'h00
`define ITC_RST_CLOCK_DIVIDER 8'h00
`define ITC_RST_EVENT 4'h0

// ----------------------------------------
// hold-time table coefficients, in module clock cycles
// ----------------------------------------
`define ITC_DIV_BASE 9'h014
`define ITC_DIV_STEP 9'h004
`define ITC_START_TRIM 9'h004
`define ITC_STOP_EXTRA 9'h002
`define ITC_SDA_BASE 9'h002

// ----------------------------------------
// bus responses
// ----------------------------------------
`define ITC_RESP_OKAY 2'b00
`define ITC_RESP_SLVERR 2'b10

`endif

// file: hdl/itc_hold_table.v
/*
  clock-rate index lookup: divider, data hold, start hold and stop hold
  counts for one index, before the multiplier factor is applied.
  assumes a 6-bit index; purely combinational.
*/
`timescale 1ns/10ps
`include "itc_defines.vh"

module itc_hold_table (
  input wire [5:0] rate_index,
  output wire [8:0] scl_divider,
  output wire [8:0] half_period,
  output wire [8:0] data_hold,
  output wire [8:0] start_hold,
  output wire [8:0] stop_hold
);

  // ----------------------------------------
  // table
  // ----------------------------------------
  // arithmetic instead of a rom: every index stays monotonic and data hold
  // stays well inside the low half, so the sequencer never skips a point
  wire [8:0] index_ext;
  assign index_ext = {3'b000, rate_index};
  assign scl_divider = `ITC_DIV_BASE + ((index_ext * `ITC_DIV_STEP) & 9'h1ff);
  assign half_period = {1'b0, scl_divider[8:1]};
  assign data_hold = `ITC_SDA_BASE + {5'b00000, rate_index[5:2]};
  assign start_hold = half_period - `ITC_START_TRIM;
  assign stop_hold = half_period + `ITC_STOP_EXTRA;

endmodule

// file: hdl/itc_ctrl.v
/*
  two-wire bus timing and control block: control_one and clock_divider
  registers over axi4-lite, start/stop generation with hold timing, bit
  clock generation, bus start/stop detection and a masked interrupt.
  assumes scl/sda inputs already synchronous to aclk and an external
  open-drain pad (oe high pulls the line low).
*/
// Summary of operation
// - start hold is clock times mul times count
// - stop hold runs from scl rise to sda rise
// - stop hold is clock times mul times count
// - module_on low disables the sequencer, bus detection and irq, but not register access
// - irq_permit low suppresses the interrupt request
// - master_select rising issues start, enters master
// - master_select falling issues stop, back to slave
// - transfer_tx picks direction: 0 receive, 1 transmit
// - bit rate is clock over mul times divider
// - mul code 00/01/10 gives factor 1/2/4
// - sda changes data hold after scl falls
// - start hold from sda fall to scl fall
`timescale 1ns/10ps
`include "itc_defines.vh"

module itc_ctrl #(
  parameter ADDR_W = 8,
  parameter CNT_W = 12
) (
  input wire aclk,
  input wire aresetn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire scl_i,
  output wire scl_o,
  output reg scl_oe,
  input wire sda_i,
  output wire sda_o,
  output reg sda_oe,
  input wire tx_bit,
  output reg bit_taken,
  output reg rx_bit,
  output reg rx_bit_valid,
  input wire slave_read_write_flag,
  output wire transfer_tx,
  output wire master_active,
  output wire wakeup_permit,
  output wire ack_drive_value,
  output wire irq
);

  // ----------------------------------------
  // state encoding
  // ----------------------------------------
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_START = 5'b00010;
  localparam [4:0] ST_LOW = 5'b00100;
  localparam [4:0] ST_HIGH = 5'b01000;
  localparam [4:0] ST_STOP = 5'b10000;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // reserved multiplier code falls back to x1 rather than stalling the bus
  function [CNT_W-1:0] scale;
    input [8:0] count;
    input [1:0] mul_code;
    reg [CNT_W-1:0] wide;
    begin
      wide = {{(CNT_W-9){1'b0}}, count};
      case (mul_code)
        `ITC_MUL_X2: scale = wide << 1;
        `ITC_MUL_X4: scale = wide << 2;
        default: scale = wide;
      endcase
    end
  endfunction

  function mapped;
    input [ADDR_W-1:0] addr;
    begin
      mapped = (addr == `ITC_ADDR_CLOCK_DIVIDER) || (addr == `ITC_ADDR_CONTROL_ONE) ||
               (addr == `ITC_ADDR_EVENT_STATUS) || (addr == `ITC_ADDR_EVENT_MASK) ||
               (addr == `ITC_ADDR_BLOCK_STATE);
    end
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg module_on;
  reg irq_permit;
  reg master_select;
  reg transfer_dir;
  reg ack_drive;
  reg wake_permit;
  reg [1:0] speed_multiplier;
  reg [5:0] clock_rate_index;
  reg [`ITC_EV_W-1:0] event_status;
  reg [`ITC_EV_W-1:0] event_mask;
  reg start_pend;
  reg stop_pend;
  reg bus_busy;
  reg prev_scl;
  reg prev_sda;
  reg [4:0] state;
  reg [CNT_W-1:0] cnt;
  reg stopping;
  reg ev_start_done;
  reg ev_stop_done;

  // ----------------------------------------
  // hold-time lookup
  // ----------------------------------------
  wire [8:0] raw_div;
  wire [8:0] raw_half;
  wire [8:0] raw_sda;
  wire [8:0] raw_start;
  wire [8:0] raw_stop;

  itc_hold_table u_table (
    .rate_index(clock_rate_index),
    .scl_divider(raw_div),
    .half_period(raw_half),
    .data_hold(raw_sda),
    .start_hold(raw_start),
    .stop_hold(raw_stop)
  );

  wire [CNT_W-1:0] half_t;
  wire [CNT_W-1:0] sda_t;
  wire [CNT_W-1:0] start_t;
  wire [CNT_W-1:0] stop_t;
  assign half_t = scale(raw_half, speed_multiplier);
  assign sda_t = scale(raw_sda, speed_multiplier);
  assign start_t = scale(raw_start, speed_multiplier);
  assign stop_t = scale(raw_stop, speed_multiplier);

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  reg aw_held;
  reg w_held;
  reg [ADDR_W-1:0] aw_addr;
  reg [7:0] w_byte;
  reg w_lane0;
  wire do_write;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= {ADDR_W{1'b0}};
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ITC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr) ? `ITC_RESP_OKAY : `ITC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire wr_ok;
  wire wr_ctl;
  wire wr_div;
  wire wr_stat;
  wire wr_mask;
  assign wr_ok = do_write && w_lane0;
  assign wr_ctl = wr_ok && (aw_addr == `ITC_ADDR_CONTROL_ONE);
  assign wr_div = wr_ok && (aw_addr == `ITC_ADDR_CLOCK_DIVIDER);
  assign wr_stat = wr_ok && (aw_addr == `ITC_ADDR_EVENT_STATUS);
  assign wr_mask = wr_ok && (aw_addr == `ITC_ADDR_EVENT_MASK);

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  wire [7:0] control_one_rd;
  wire [7:0] block_state_rd;
  reg [7:0] rd_byte;
  assign control_one_rd = {module_on, irq_permit, master_select, transfer_dir,
                           ack_drive, 1'b0, wake_permit, 1'b0};
  assign block_state_rd = {4'h0, slave_read_write_flag, bus_busy, transfer_dir, master_active};
  assign s_axi_arready = !s_axi_rvalid;

  always @* begin
    case (s_axi_araddr)
      `ITC_ADDR_CLOCK_DIVIDER: rd_byte = {speed_multiplier, clock_rate_index};
      `ITC_ADDR_CONTROL_ONE: rd_byte = control_one_rd;
      `ITC_ADDR_EVENT_STATUS: rd_byte = {4'h0, event_status};
      `ITC_ADDR_EVENT_MASK: rd_byte = {4'h0, event_mask};
      `ITC_ADDR_BLOCK_STATE: rd_byte = block_state_rd;
      default: rd_byte = 8'h00;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ITC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= mapped(s_axi_araddr) ? `ITC_RESP_OKAY : `ITC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // control and divider registers
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      {module_on, irq_permit, master_select, transfer_dir} <= 4'h0;
      {ack_drive, wake_permit} <= 2'b00;
      {speed_multiplier, clock_rate_index} <= `ITC_RST_CLOCK_DIVIDER;
    end else begin
      if (wr_ctl) begin
        module_on <= w_byte[`ITC_C1_MODULE_ON];
        irq_permit <= w_byte[`ITC_C1_IRQ_PERMIT];
        master_select <= w_byte[`ITC_C1_MASTER_SELECT];
        transfer_dir <= w_byte[`ITC_C1_TRANSFER_TX];
        ack_drive <= w_byte[`ITC_C1_ACK_DRIVE];
        wake_permit <= w_byte[`ITC_C1_WAKEUP_PERMIT];
      end
      if (wr_div) begin
        speed_multiplier <= w_byte[`ITC_F_MUL_HI:`ITC_F_MUL_LO];
        clock_rate_index <= w_byte[`ITC_F_RATE_HI:`ITC_F_RATE_LO];
      end
    end
  end

  // edge of master_select becomes a pending request held until the
  // sequencer can act, so a write during a bit is not lost
  wire mst_rise;
  wire mst_fall;
  wire take_start;
  wire take_stop;
  assign mst_rise = wr_ctl && module_on && !master_select && w_byte[`ITC_C1_MASTER_SELECT];
  assign mst_fall = wr_ctl && module_on && master_select && !w_byte[`ITC_C1_MASTER_SELECT];
  assign take_start = (state == ST_IDLE) && start_pend && !bus_busy;
  assign take_stop = (state == ST_LOW) && (cnt == sda_t - 1'b1);

  always @(posedge aclk) begin
    if (!aresetn || !module_on) begin
      start_pend <= 1'b0;
      stop_pend <= 1'b0;
    end else begin
      if (mst_rise) begin
        start_pend <= 1'b1;
      end else if (take_start || mst_fall) begin
        start_pend <= 1'b0;
      end
      if (mst_fall && (state != ST_IDLE || !start_pend)) begin
        stop_pend <= 1'b1;
      end else if (take_stop || state == ST_IDLE) begin
        stop_pend <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // bus condition detection
  // ----------------------------------------
  wire bus_start;
  wire bus_stop;
  assign bus_start = module_on && scl_i && prev_scl && prev_sda && !sda_i;
  assign bus_stop = module_on && scl_i && prev_scl && !prev_sda && sda_i;

  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_scl <= 1'b1;
      prev_sda <= 1'b1;
      bus_busy <= 1'b0;
    end else begin
      prev_scl <= scl_i;
      prev_sda <= sda_i;
      if (!module_on || bus_stop) begin
        bus_busy <= 1'b0;
      end else if (bus_start) begin
        bus_busy <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // master sequencer
  // ----------------------------------------
  // the high half counts only while scl reads high, so a slave that
  // stretches the clock lengthens the bit instead of being overrun
  always @(posedge aclk) begin
    if (!aresetn || !module_on) begin
      state <= ST_IDLE;
      cnt <= {CNT_W{1'b0}};
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      stopping <= 1'b0;
      bit_taken <= 1'b0;
      rx_bit <= 1'b0;
      rx_bit_valid <= 1'b0;
      ev_start_done <= 1'b0;
      ev_stop_done <= 1'b0;
    end else begin
      bit_taken <= 1'b0;
      rx_bit_valid <= 1'b0;
      ev_start_done <= 1'b0;
      ev_stop_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          cnt <= {CNT_W{1'b0}};
          scl_oe <= 1'b0;
          sda_oe <= 1'b0;
          if (take_start) begin
            sda_oe <= 1'b1;
            state <= ST_START;
          end
        end
        ST_START: begin
          cnt <= cnt + 1'b1;
          if (cnt == start_t - 1'b1) begin
            scl_oe <= 1'b1;
            cnt <= {CNT_W{1'b0}};
            stopping <= 1'b0;
            ev_start_done <= 1'b1;
            state <= ST_LOW;
          end
        end
        ST_LOW: begin
          cnt <= cnt + 1'b1;
          if (take_stop) begin
            stopping <= stop_pend;
            if (stop_pend) begin
              sda_oe <= 1'b1;
            end else if (transfer_dir) begin
              sda_oe <= !tx_bit;
              bit_taken <= 1'b1;
            end else begin
              sda_oe <= 1'b0;
            end
          end
          if (cnt == half_t - 1'b1) begin
            scl_oe <= 1'b0;
            cnt <= {CNT_W{1'b0}};
            state <= stopping ? ST_STOP : ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (scl_i) begin
            cnt <= cnt + 1'b1;
            if (cnt == {CNT_W{1'b0}} && !transfer_dir) begin
              rx_bit <= sda_i;
              rx_bit_valid <= 1'b1;
            end
            if (cnt == half_t - 1'b1) begin
              scl_oe <= 1'b1;
              cnt <= {CNT_W{1'b0}};
              state <= ST_LOW;
            end
          end
        end
        ST_STOP: begin
          if (scl_i) begin
            cnt <= cnt + 1'b1;
            if (cnt == stop_t - 1'b1) begin
              sda_oe <= 1'b0;
              ev_stop_done <= 1'b1;
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // events and interrupt
  // ----------------------------------------
  wire [`ITC_EV_W-1:0] ev_set;
  assign ev_set = {bus_stop, bus_start, ev_stop_done, ev_start_done};

  // set beats a write-one-to-clear in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      event_status <= `ITC_RST_EVENT;
      event_mask <= `ITC_RST_EVENT;
    end else begin
      event_status <= (event_status & ~(wr_stat ? w_byte[`ITC_EV_W-1:0] : `ITC_RST_EVENT)) | ev_set;
      if (wr_mask) begin
        event_mask <= w_byte[`ITC_EV_W-1:0];
      end
    end
  end

  assign irq = module_on && irq_permit && |(event_status & event_mask);

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign transfer_tx = transfer_dir;
  assign master_active = (state != ST_IDLE);
  assign wakeup_permit = wake_permit;
  assign ack_drive_value = ack_drive;

endmodule

// file: bench/itc_ctrl_sva.sv
/*
  checker of the timing and control block: register bus answers, reset
  state, start hold, data hold and low half counts on the bus pins.
  assumes write address and write data are offered in the same cycle.
*/
`timescale 1ns/10ps
module itc_ctrl_sva #(
  parameter ADDR_W = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire scl_oe,
  input wire sda_oe,
  input wire master_active,
  input wire irq
);
  // ----------------------------------------
  // divider snoop and hold counters
  // ----------------------------------------
  logic [7:0] fdiv;
  logic [12:0] cnt;
  logic [12:0] lcnt;
  logic psda;
  wire [3:0] m = (fdiv[7:6] == 2'h1) ? 4'h2 : (fdiv[7:6] == 2'h2) ? 4'h4 : 4'h1;
  wire [8:0] half = (9'h014 + {1'b0, fdiv[5:0], 2'h0}) >> 1;
  wire [12:0] start_c = (half - 9'h004) * m;
  wire [12:0] sda_c = (9'h002 + fdiv[5:2]) * m;
  wire [12:0] half_c = half * m;
  // start count only begins on an sda pull with scl free, so data phases never start it
  always @(posedge aclk) begin
    if (!aresetn) begin
      fdiv <= 8'h00;
      cnt <= 13'h0000;
      lcnt <= 13'h0000;
      psda <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_awaddr == 'h04 && s_axi_wstrb[0]) begin
        fdiv <= s_axi_wdata[7:0];
      end
      psda <= sda_oe;
      cnt <= (sda_oe && !scl_oe && (cnt != 13'h0000 || !psda)) ? cnt + 13'h0001 : 13'h0000;
      lcnt <= scl_oe ? lcnt + 13'h0001 : 13'h0000;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence c1_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 'h08;
  endsequence
  reset_quiet_a: assert property ($rose(aresetn) |-> !scl_oe && !sda_oe && !master_active && !irq)
    else $error("bus pins or irq active after reset");
  idle_quiet_a: assert property (!master_active |-> !scl_oe && !sda_oe)
    else $error("bus pulled while not master");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  reserved_zero_a: assert property (c1_read |=> s_axi_rdata[2] == 1'b0 && s_axi_rdata[0] == 1'b0)
    else $error("reserved control bits read nonzero");
  start_hold_a: assert property ($rose(scl_oe) && cnt != 13'h0000 |-> cnt == start_c)
    else $error("start hold count wrong");
  data_hold_a: assert property (scl_oe && $past(scl_oe) && $changed(sda_oe) |-> lcnt == sda_c)
    else $error("data hold count wrong");
  low_half_a: assert property ($fell(scl_oe) |-> lcnt == half_c)
    else $error("scl low half wrong");
endmodule
bind itc_ctrl itc_ctrl_sva #(.ADDR_W(ADDR_W)) u_sva (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .scl_oe, .sda_oe, .master_active, .irq);

// file: bench/itc_bus_model.sv
/*
  far side of the two-wire bus: pull-ups and a slave that stretches scl.
  assumes open-drain enables from the block, high meaning pull low.
*/
`timescale 1ns/10ps
module itc_bus_model #(
  parameter STRETCH = 5
) (
  input wire aclk,
  input wire scl_oe,
  input wire sda_oe,
  output wire scl_i,
  output wire sda_i
);
  // ----------------------------------------
  // clock stretch
  // ----------------------------------------
  logic [3:0] rel = 4'h0;
  // holding scl low after release proves counts start at the real scl rise
  always @(posedge aclk) begin
    if (scl_oe) begin
      rel <= 4'h0;
    end else if (rel != 4'hf) begin
      rel <= rel + 4'h1;
    end
  end
  assign scl_i = !(scl_oe || rel < STRETCH);
  assign sda_i = !sda_oe;
endmodule

// file: bench/itc_ctrl_test.sv
/*
  testbench of the timing and control block: register access, start and
  stop timing for every multiplier code, direction and interrupt gating.
  assumes the bus model stands on the pins.
*/
`timescale 1ns/10ps
module itc_ctrl_test;
  logic aclk;
  logic aresetn;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic tx_bit = 1'b0, slave_read_write_flag = 1'b0, slow = 1'b0, b = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire scl_i, sda_i, scl_oe, sda_oe, rx_bit, rx_bit_valid, transfer_tx, master_active, irq;
  wire bit_taken, wakeup_permit, ack_drive_value;
  int err_total = 0, tests_run = 0;
  int k, n, h, m;
  itc_ctrl dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scl_i, .scl_o(), .scl_oe, .sda_i,
    .sda_o(), .sda_oe, .tx_bit, .bit_taken, .rx_bit, .rx_bit_valid, .slave_read_write_flag, .transfer_tx,
    .master_active, .wakeup_permit, .ack_drive_value, .irq);
  itc_bus_model bus_far (.aclk, .scl_oe, .sda_oe, .scl_i, .sda_i);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // readies are read right after the edge, before that edge's updates land
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= !slow;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= !slow;
    end
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (wr ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready) begin
        q = s_axi_rdata;
        r = wr ? s_axi_bresp : s_axi_rresp;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end else if (wr ? s_axi_bvalid : s_axi_rvalid) begin
        s_axi_bready <= wr;
        s_axi_rready <= !wr;
      end
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    logic [31:0] q;
    logic [1:0] r;
    bus(1'b1, a, d, q, r);
    check("bresp", {30'h0, r}, {30'h0, er});
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    logic [31:0] q;
    logic [1:0] r;
    bus(1'b0, a, 32'h0, q, r);
    check("rdata", q, e);
    check("rresp", {30'h0, r}, {30'h0, er});
  endtask
  task finish_test;
    $display("tests %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    finish_test();
  end
  initial begin
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h08, 32'h0);
    rd(8'h04, 32'h0);
    // ready held back: the slave must keep its answer standing
    slow = 1'b1;
    rd(8'h30, 32'h0, 2'h2);
    wr(8'h30, 32'hff, 2'h2);
    slow = 1'b0;
    wr(8'h08, 32'h6f);
    s_axi_wstrb <= 4'h0;
    wr(8'h08, 32'hff);
    s_axi_wstrb <= 4'h1;
    rd(8'h08, 32'h6a);
    check("ack and wakeup", {ack_drive_value, wakeup_permit}, 2'h3);
    repeat (4) @(posedge aclk);
    check("sda_oe", sda_oe, 1'b0);
    slave_read_write_flag <= 1'b1;
    rd(8'h18, 32'h08);
    wr(8'h08, 32'h10);
    check("transfer_tx", transfer_tx, 1'b1);
    wr(8'h08, 32'h0);
    wr(8'h14, 32'h3);
    // index 0: half 10, start 6, data hold 2, stop 12; code 3 falls back to x1
    for (k = 0; k < 4; k++) begin
      m = (k == 1) ? 2 : (k == 2) ? 4 : 1;
      tx_bit <= (k != 3);
      wr(8'h04, {24'h0, k[1:0], 6'h00});
      wr(8'h08, 32'h80);
      wr(8'h08, (k != 3) ? 32'hb0 : 32'ha0);
      while (!sda_oe) @(posedge aclk);
      for (n = 0; !scl_oe; n++) @(posedge aclk);
      check("start hold", n, 6 * m);
      check("master_active", master_active, 1'b1);
      h = 0;
      for (n = 0; scl_oe; n++) begin
        @(posedge aclk);
        if (!sda_oe && h == 0) begin
          h = n + 1;
          b = bit_taken;
        end
      end
      check("sda hold", h, 2 * m);
      check("bit_taken", b, k != 3);
      check("low half", n, 10 * m);
      check("transfer_tx", transfer_tx, k != 3);
      for (n = 0; !rx_bit_valid && n < 8; n++) @(posedge aclk);
      if (k == 3) check("rx bit", {rx_bit_valid, rx_bit}, 2'h3);
      wr(8'h08, 32'h80);
      while (!(sda_oe && scl_i && !scl_oe)) @(posedge aclk);
      for (n = 0; sda_oe; n++) @(posedge aclk);
      check("stop hold", n, 12 * m);
      repeat (2) @(posedge aclk);
      check("master_active", master_active, 1'b0);
    end
    rd(8'h10, 32'h0f);
    check("irq", irq, 1'b0);
    wr(8'h08, 32'hc0);
    check("irq", irq, 1'b1);
    wr(8'h14, 32'h0);
    check("irq", irq, 1'b0);
    wr(8'h14, 32'h3);
    wr(8'h10, 32'h0f);
    rd(8'h10, 32'h0);
    check("irq", irq, 1'b0);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h08, 32'h0);
    finish_test();
  end
endmodule
